// ===== mrs_frame_mem.sv
// Purpose: Frame byte store with registered read data
// Assumes: One write port and one read port on the same clock
// Notes:   Read data appear one clock after the read address
`timescale 1ns/1ps
module mrs_frame_mem #(
  parameter int unsigned DW    = 8,
  parameter int unsigned DEPTH = 256
) (
  input  wire logic                     mclk_i,
  input  wire logic                     we_i,
  input  wire logic [$clog2(DEPTH)-1:0] waddr_i,
  input  wire logic [DW-1:0]            wdata_i,
  input  wire logic [$clog2(DEPTH)-1:0] raddr_i,
  output logic      [DW-1:0]            rdata_o
);
  initial begin
    if (DW == 0 || DEPTH < 2) $error("mrs_frame_mem: bad geometry");
  end

  logic [DW-1:0] mem_reg [DEPTH];

  // No reset on the array, so it maps onto block memory
  always_ff @(posedge mclk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end
endmodule

// ===== mrs_slave.sv
// Purpose: Modbus RTU slave frame handler, byte level
// Assumes: Byte UART outside on mclk_i; application register port outside
// Notes:   Package and top module share this file
`timescale 1ns/1ps
package mrs_pkg;
  localparam logic [7:0]  ADDR_BCAST  = 8'h00;
  localparam logic [7:0]  ADDR_MAX    = 8'hf7;
  localparam logic [7:0]  FC_RD_HOLD  = 8'h03;
  localparam logic [7:0]  FC_WR_ONE   = 8'h06;
  localparam logic [7:0]  FC_WR_MANY  = 8'h10;
  localparam logic [7:0]  FC_RD_INPUT = 8'h04;
  localparam logic [7:0]  EXC_FLAG    = 8'h80;
  localparam logic [7:0]  ERR_FUNC    = 8'h01;
  localparam logic [7:0]  ERR_ADDR    = 8'h02;
  localparam logic [7:0]  ERR_COUNT   = 8'h03;
  localparam logic [7:0]  ERR_ACCESS  = 8'h04;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'ha001;
  localparam logic [6:0]  RD_MAX      = 7'h7d;
  localparam logic [6:0]  WR_MAX      = 7'h7b;
  localparam logic [8:0]  LEN_FIXED   = 9'h008;
  localparam logic [8:0]  LEN_MIN     = 9'h004;
  localparam logic [8:0]  LEN_LIMIT   = 9'h100;
  localparam logic [7:0]  DATA_IDX    = 8'h07;
  localparam int unsigned CHAR_BITS   = 11;
  localparam int unsigned END_HALFCH  = 7;
  localparam int unsigned ABT_HALFCH  = 3;
  localparam int unsigned BAUDS [5]   = '{2400, 4800, 9600, 19200, 38400};
  localparam logic [2:0]  BAUD_DEF    = 3'h2;
  localparam logic [2:0]  BAUD_LAST   = 3'h4;

  typedef enum {ST_RX, ST_EVAL, ST_WRD, ST_REQ, ST_STO, ST_TX, ST_TXW} mrs_state_type;
  typedef enum {K_EXC, K_ECHO, K_RD} mrs_kind_type;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] v;
    v = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      v = v[0] ? ((v >> 1) ^ CRC_POLY) : (v >> 1);
    end
    return v;
  endfunction
endpackage

module mrs_slave import mrs_pkg::*; #(
  parameter int unsigned CLK_HZ      = 50_000_000,
  parameter int unsigned HOLD_COUNT  = 65536,
  parameter int unsigned INPUT_COUNT = 65536
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  own_addr_i,
  input  wire logic [2:0]  baud_sel_i,
  input  wire logic [7:0]  rx_data_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_err_i,
  input  wire logic        tx_busy_i,
  output logic      [7:0]  tx_data_o,
  output logic             tx_start_o,
  output logic             tx_drive_o,
  output logic             reg_req_o,
  output logic             reg_we_o,
  output logic             reg_input_o,
  output logic      [15:0] reg_addr_o,
  output logic      [15:0] reg_wdata_o,
  input  wire logic [15:0] reg_rdata_i,
  input  wire logic        reg_ack_i,
  input  wire logic        reg_err_i
);
  initial begin
    if (CLK_HZ < 1_000_000 || CLK_HZ > 400_000_000) $error("mrs_slave: CLK_HZ out of range");
    if (HOLD_COUNT > 65536 || INPUT_COUNT > 65536) $error("mrs_slave: map too large");
  end

  // Least time rounds up, longest time rounds down
  function automatic logic [23:0] gap_cyc(input int unsigned half, input int unsigned baud,
                                          input bit up);
    longint unsigned num;
    longint unsigned den;
    num = longint'(half) * CHAR_BITS * CLK_HZ;
    den = longint'(baud) * 2;
    return 24'(up ? (num + den - 1) / den : num / den);
  endfunction

  localparam logic [23:0] END_CYC [5] = '{gap_cyc(END_HALFCH, BAUDS[0], 1'b1),
    gap_cyc(END_HALFCH, BAUDS[1], 1'b1), gap_cyc(END_HALFCH, BAUDS[2], 1'b1),
    gap_cyc(END_HALFCH, BAUDS[3], 1'b1), gap_cyc(END_HALFCH, BAUDS[4], 1'b1)};
  localparam logic [23:0] ABT_CYC [5] = '{gap_cyc(ABT_HALFCH, BAUDS[0], 1'b0),
    gap_cyc(ABT_HALFCH, BAUDS[1], 1'b0), gap_cyc(ABT_HALFCH, BAUDS[2], 1'b0),
    gap_cyc(ABT_HALFCH, BAUDS[3], 1'b0), gap_cyc(ABT_HALFCH, BAUDS[4], 1'b0)};

  mrs_state_type state_reg;
  mrs_kind_type  kind_reg;
  logic [23:0]   gap_reg;
  logic          armed_reg;
  logic          bad_reg;
  logic [8:0]    len_reg;
  logic [15:0]   crc_rx_reg;
  logic [15:0]   crc_tx_reg;
  logic [7:0]    addr_b_reg;
  logic [7:0]    fc_b_reg;
  logic [15:0]   w0_reg;
  logic [15:0]   w1_reg;
  logic [7:0]    bc_reg;
  logic [7:0]    err_reg;
  logic [6:0]    wcnt_reg;
  logic [1:0]    sub_reg;
  logic [7:0]    lo_reg;
  logic [8:0]    idx_reg;
  logic          hold_reg;
  logic [7:0]    mem_rdata;

  // Baud selection and silence thresholds
  wire [2:0]  bsel      = (baud_sel_i > BAUD_LAST) ? BAUD_DEF : baud_sel_i;
  wire [23:0] end_cyc   = END_CYC[bsel];
  wire [23:0] abt_cyc   = ABT_CYC[bsel];
  wire        gap_end   = gap_reg >= end_cyc;
  wire        gap_abort = gap_reg > abt_cyc;

  // Frame qualification
  wire own_ok    = (own_addr_i != ADDR_BCAST) && (own_addr_i <= ADDR_MAX);
  wire is_bcast  = addr_b_reg == ADDR_BCAST;
  wire addr_hit  = is_bcast || (own_ok && addr_b_reg == own_addr_i);
  wire frame_ok  = !bad_reg && len_reg >= LEN_MIN && crc_rx_reg == 16'h0000;
  wire frame_end = state_reg == ST_RX && armed_reg && len_reg != 9'h000 && gap_end;
  wire rx_take   = state_reg == ST_RX && rx_valid_i && armed_reg;
  wire frame_go  = frame_end && frame_ok && addr_hit;

  // Request decoding
  wire is_read   = fc_b_reg == FC_RD_HOLD || fc_b_reg == FC_RD_INPUT;
  wire [6:0] n7  = w1_reg[6:0];
  wire n_hi_zero = w1_reg[15:7] == 9'h000;
  wire rd_cnt_ok = n_hi_zero && n7 != 7'h00 && n7 <= RD_MAX;
  wire wr_cnt_ok = n_hi_zero && n7 != 7'h00 && n7 <= WR_MAX && bc_reg == {n7, 1'b0};
  wire wr_len_ok = len_reg == 9'(LEN_FIXED + 9'h001 + {n7, 1'b0});
  wire [16:0] span  = {1'b0, w0_reg} + {1'b0, w1_reg};
  wire [16:0] limit = (fc_b_reg == FC_RD_INPUT) ? 17'(INPUT_COUNT) : 17'(HOLD_COUNT);
  wire span_ok   = span <= limit;
  wire one_ok    = {1'b0, w0_reg} < 17'(HOLD_COUNT);
  wire last_reg  = wcnt_reg == 7'(n7 - 7'h01);

  // Reply assembly
  wire [7:0] fc_out   = (kind_reg == K_EXC) ? (fc_b_reg | EXC_FLAG) : fc_b_reg;
  wire [8:0] body_len = (kind_reg == K_EXC) ? 9'h003 : (kind_reg == K_ECHO) ? 9'h006 :
                        9'(9'h003 + {n7, 1'b0});
  wire [8:0] total    = 9'(body_len + 9'h002);
  wire [7:0] echo_b   = (idx_reg == 9'h002) ? w0_reg[15:8] : (idx_reg == 9'h003) ? w0_reg[7:0] :
                        (idx_reg == 9'h004) ? w1_reg[15:8] : w1_reg[7:0];
  wire [7:0] tx_byte  = (idx_reg == 9'h000) ? addr_b_reg :
                        (idx_reg == 9'h001) ? fc_out :
                        (idx_reg == body_len) ? crc_tx_reg[7:0] :
                        (idx_reg == 9'(body_len + 9'h001)) ? crc_tx_reg[15:8] :
                        (kind_reg == K_EXC) ? err_reg :
                        (kind_reg == K_ECHO) ? echo_b :
                        (idx_reg == 9'h002) ? {n7, 1'b0} : mem_rdata;

  // Shared frame store: received bytes, later read values
  wire       mem_we    = rx_take || (state_reg == ST_REQ && reg_ack_i && !reg_we_o) ||
                         state_reg == ST_STO;
  wire [7:0] mem_waddr = (state_reg == ST_RX) ? len_reg[7:0] :
                         {wcnt_reg, state_reg == ST_STO};
  wire [7:0] mem_wdata = (state_reg == ST_RX) ? rx_data_i :
                         (state_reg == ST_STO) ? lo_reg : reg_rdata_i[15:8];
  wire [7:0] mem_raddr = (state_reg == ST_WRD) ? 8'(DATA_IDX + {wcnt_reg, sub_reg[0]}) :
                         8'(idx_reg - 9'h003);

  mrs_frame_mem #(.DW(8), .DEPTH(256)) u_mem (
    .mclk_i  (mclk_i),
    .we_i    (mem_we),
    .waddr_i (mem_waddr),
    .wdata_i (mem_wdata),
    .raddr_i (mem_raddr),
    .rdata_o (mem_rdata)
  );

  // Line silence timer, held clear while this end owns the line
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || rx_valid_i || state_reg != ST_RX) begin
      gap_reg <= 24'h000000;
    end else if (!gap_end) begin
      gap_reg <= 24'(gap_reg + 24'h000001);
    end
  end

  // Receiver: byte capture, framing and running CRC
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      armed_reg  <= 1'b0;
      bad_reg    <= 1'b0;
      len_reg    <= 9'h000;
      crc_rx_reg <= CRC_INIT;
      addr_b_reg <= 8'h00;
      fc_b_reg   <= 8'h00;
      w0_reg     <= 16'h0000;
      w1_reg     <= 16'h0000;
      bc_reg     <= 8'h00;
    end else if (state_reg == ST_TX && idx_reg == total) begin
      armed_reg <= 1'b0;
    end else if (state_reg == ST_EVAL) begin
      // Length is kept until the request has been judged
      len_reg    <= 9'h000;
      bad_reg    <= 1'b0;
      crc_rx_reg <= CRC_INIT;
    end else if (state_reg == ST_RX) begin
      if (gap_end) begin
        armed_reg <= 1'b1;
      end
      if (frame_end) begin
        if (!frame_go) begin
          len_reg    <= 9'h000;
          bad_reg    <= 1'b0;
          crc_rx_reg <= CRC_INIT;
        end
      end else if (rx_take) begin
        len_reg    <= (len_reg == LEN_LIMIT) ? len_reg : 9'(len_reg + 9'h001);
        crc_rx_reg <= crc_step(crc_rx_reg, rx_data_i);
        // Parity or framing errors come flagged from the UART
        if (rx_err_i || len_reg == LEN_LIMIT || (len_reg != 9'h000 && gap_abort)) begin
          bad_reg <= 1'b1;
        end
        if (len_reg == 9'h000) addr_b_reg <= rx_data_i;
        if (len_reg == 9'h001) fc_b_reg <= rx_data_i;
        if (len_reg == 9'h002) w0_reg[15:8] <= rx_data_i;
        if (len_reg == 9'h003) w0_reg[7:0] <= rx_data_i;
        if (len_reg == 9'h004) w1_reg[15:8] <= rx_data_i;
        if (len_reg == 9'h005) w1_reg[7:0] <= rx_data_i;
        if (len_reg == 9'h006) bc_reg <= rx_data_i;
      end
    end
  end

  // Command sequencer and transmitter
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_reg   <= ST_RX;
      kind_reg    <= K_EXC;
      err_reg     <= 8'h00;
      wcnt_reg    <= 7'h00;
      sub_reg     <= 2'h0;
      lo_reg      <= 8'h00;
      idx_reg     <= 9'h000;
      hold_reg    <= 1'b0;
      crc_tx_reg  <= CRC_INIT;
      tx_data_o   <= 8'h00;
      tx_start_o  <= 1'b0;
      tx_drive_o  <= 1'b0;
      reg_req_o   <= 1'b0;
      reg_we_o    <= 1'b0;
      reg_input_o <= 1'b0;
      reg_addr_o  <= 16'h0000;
      reg_wdata_o <= 16'h0000;
    end else begin
      tx_start_o <= 1'b0;
      unique case (state_reg)
        ST_RX: begin
          if (frame_go) state_reg <= ST_EVAL;
          idx_reg    <= 9'h000;
          crc_tx_reg <= CRC_INIT;
          wcnt_reg   <= 7'h00;
          sub_reg    <= 2'h0;
        end
        ST_EVAL: begin
          reg_addr_o  <= w0_reg;
          reg_input_o <= fc_b_reg == FC_RD_INPUT;
          kind_reg    <= K_EXC;
          state_reg   <= is_bcast ? ST_RX : ST_TX;
          if (is_read) begin
            reg_we_o <= 1'b0;
            if (len_reg != LEN_FIXED || is_bcast) begin
              state_reg <= ST_RX;
            end else if (!rd_cnt_ok) begin
              err_reg <= ERR_COUNT;
            end else if (!span_ok) begin
              err_reg <= ERR_ADDR;
            end else begin
              state_reg <= ST_REQ;
              reg_req_o <= 1'b1;
            end
          end else if (fc_b_reg == FC_WR_ONE) begin
            reg_we_o    <= 1'b1;
            reg_wdata_o <= w1_reg;
            if (len_reg != LEN_FIXED) begin
              state_reg <= ST_RX;
            end else if (!one_ok) begin
              err_reg <= ERR_ADDR;
            end else begin
              state_reg <= ST_REQ;
              reg_req_o <= 1'b1;
            end
          end else if (fc_b_reg == FC_WR_MANY) begin
            reg_we_o <= 1'b1;
            if (!wr_cnt_ok || !wr_len_ok) begin
              err_reg <= ERR_COUNT;
            end else if (!span_ok) begin
              err_reg <= ERR_ADDR;
            end else begin
              state_reg <= ST_WRD;
            end
          end else begin
            err_reg <= ERR_FUNC;
          end
        end
        ST_WRD: begin
          sub_reg <= 2'(sub_reg + 2'h1);
          if (sub_reg == 2'h1) reg_wdata_o[15:8] <= mem_rdata;
          if (sub_reg == 2'h2) begin
            reg_wdata_o[7:0] <= mem_rdata;
            sub_reg   <= 2'h0;
            reg_req_o <= 1'b1;
            state_reg <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (reg_ack_i) begin
            reg_req_o <= 1'b0;
            lo_reg    <= reg_rdata_i[7:0];
            if (reg_err_i) begin
              kind_reg  <= K_EXC;
              err_reg   <= ERR_ACCESS;
              state_reg <= is_bcast ? ST_RX : ST_TX;
            end else if (!reg_we_o) begin
              state_reg <= ST_STO;
            end else if (fc_b_reg == FC_WR_ONE || last_reg) begin
              kind_reg  <= K_ECHO;
              state_reg <= is_bcast ? ST_RX : ST_TX;
            end else begin
              wcnt_reg   <= 7'(wcnt_reg + 7'h01);
              reg_addr_o <= 16'(reg_addr_o + 16'h0001);
              state_reg  <= ST_WRD;
            end
          end
        end
        ST_STO: begin
          wcnt_reg   <= 7'(wcnt_reg + 7'h01);
          reg_addr_o <= 16'(reg_addr_o + 16'h0001);
          if (last_reg) begin
            kind_reg  <= K_RD;
            state_reg <= ST_TX;
          end else begin
            reg_req_o <= 1'b1;
            state_reg <= ST_REQ;
          end
        end
        ST_TX: begin
          if (idx_reg == total) begin
            tx_drive_o <= 1'b0;
            state_reg  <= ST_RX;
          end else begin
            tx_drive_o <= 1'b1;
            tx_data_o  <= tx_byte;
            tx_start_o <= 1'b1;
            if (idx_reg < body_len) crc_tx_reg <= crc_step(crc_tx_reg, tx_byte);
            idx_reg    <= 9'(idx_reg + 9'h001);
            hold_reg   <= 1'b1;
            state_reg  <= ST_TXW;
          end
        end
        ST_TXW: begin
          // One spare cycle lets the UART raise busy; bytes go back to back
          hold_reg <= 1'b0;
          if (!hold_reg && !tx_busy_i) state_reg <= ST_TX;
        end
      endcase
    end
  end

  sequence s_last_sent;
    state_reg == ST_TX && idx_reg == total;
  endsequence

  drive_on_send_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_start_o |-> tx_drive_o) else $error("byte sent without driver enable");
  drive_release_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    s_last_sent |=> !tx_drive_o ##1 !tx_drive_o) else $error("driver held after reply");
  bcast_silent_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(tx_drive_o) |-> addr_b_reg != ADDR_BCAST) else $error("reply to broadcast");
  crc_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_reg == ST_EVAL |-> $past(crc_rx_reg) == 16'h0000) else $error("bad CRC accepted");
  addr_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_reg == ST_EVAL |-> addr_b_reg == 8'h00 || (addr_b_reg == own_addr_i &&
    own_addr_i <= 8'hf7)) else $error("foreign frame accepted");
  silence_end_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(state_reg == ST_EVAL) |-> $past(gap_reg, 2) + 24'h000001 >= $past(end_cyc, 2))
    else $error("frame ended before silence");
  gap_abort_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rx_take && !frame_end && len_reg != 9'h000 && gap_abort |=> bad_reg ##1 !frame_ok ||
    len_reg == 9'h000) else $error("late byte not discarded");
  exc_code_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_start_o && kind_reg == K_EXC && $past(idx_reg) == 9'h002 |->
    tx_data_o inside {8'h01, 8'h02, 8'h03, 8'h04}) else $error("bad error code");
  byte_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_start_o && kind_reg == K_RD && $past(idx_reg) == 9'h002 |->
    tx_data_o == {w1_reg[6:0], 1'b0}) else $error("byte count not twice count");
  echo_addr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    tx_start_o && kind_reg == K_ECHO && $past(idx_reg) == 9'h002 |->
    tx_data_o == w0_reg[15:8]) else $error("echo address wrong");
  func_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    reg_req_o |-> fc_b_reg inside {8'h03, 8'h04, 8'h06, 8'h10}) else $error("bad code served");
  many_count_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    state_reg == ST_WRD |-> w1_reg >= 16'h0001 && w1_reg <= 16'h007b)
    else $error("multi write count out of range");
endmodule

// ===== mrs_master_model.sv
// Purpose: Master end of the serial link with a byte-level UART stand-in
// Assumes: Characters appear as one-cycle byte pulses on mclk_i
// Notes:   Idle receive data shows the inverse of the last byte
`timescale 1ns/1ps
module mrs_master_model #(
  parameter int CHAR_CYC = 60
) (
  input  wire logic       mclk_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_start_i,
  input  wire logic       tx_drive_i,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_err_o,
  output logic            tx_busy_o
);
  logic [7:0] got [$];
  int         cyc = 0;
  int         last_rx = 0;
  int         first_tx = 0;
  int         bcnt = 0;
  bit         sending = 1'b0;
  bit         drive_bad = 1'b0;
  initial begin
    rx_data_o  = 8'h00;
    rx_valid_o = 1'b0;
    rx_err_o   = 1'b0;
    tx_busy_o  = 1'b0;
  end
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
  end
  // Busy rises the cycle after a start, as the slave expects
  always @(negedge mclk_i) begin
    if (tx_start_i) begin
      if (got.size() == 0) first_tx = cyc;
      got.push_back(tx_data_i);
      tx_busy_o <= 1'b1;
      bcnt      <= CHAR_CYC;
      if (tx_drive_i !== 1'b1) drive_bad = 1'b1;
    end else if (bcnt > 1) begin
      bcnt <= bcnt - 1;
    end else begin
      tx_busy_o <= 1'b0;
    end
    if (sending && tx_drive_i !== 1'b0) drive_bad = 1'b1;
  end
  // Back to back characters; gap_at forces an over-long pause
  task automatic send(input logic [7:0] b [$], input int gap_at, input int err_at);
    sending = 1'b1;
    got.delete();
    for (int i = 0; i < b.size(); i++) begin
      repeat (i == gap_at ? 500 : 1) @(negedge mclk_i);
      rx_data_o  <= b[i];
      rx_valid_o <= 1'b1;
      rx_err_o   <= (i == err_at);
      @(negedge mclk_i);
      last_rx = cyc;
      rx_valid_o <= 1'b0;
      rx_err_o   <= 1'b0;
      rx_data_o  <= ~b[i];
      repeat (CHAR_CYC - 2) @(negedge mclk_i);
    end
    sending = 1'b0;
  endtask
endmodule

// ===== modbus_rtu_slave_handler_bench.sv
// Purpose: Self-checking bench for the slave frame handler
// Assumes: 1 MHz timing base, 38400 baud then 19200 at the end, own address 11h
// Notes:   Register space cut to 256 so address faults are cheap
`timescale 1ns/1ps
module modbus_rtu_slave_handler_bench;
  typedef struct {logic [87:0] rq; int rl; logic [55:0] rp; int pl;} mrs_row_type;
  localparam int END_CYC = (77_000_000 + 76_799) / 76_800;
  localparam int END_CYC3 = (77_000_000 + 38_399) / 38_400;
  logic        mclk_i = 1'b0;
  logic        rst_n_i, rx_valid_i, rx_err_i, tx_busy_i, tx_start_o, tx_drive_o;
  logic        reg_req_o, reg_we_o, reg_input_o, reg_ack_i, reg_err_i;
  logic [7:0]  own_addr_i, rx_data_i, tx_data_o;
  logic [2:0]  baud_sel_i;
  logic [15:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic [31:0] wr_last;
  logic [7:0]  q [$], e [$];
  int          bad_count, n_compared, cycles, rq_age;
  mrs_row_type rows [17] = '{
    '{88'h11_03_0010_0002, 6, 56'h11_03_04_ffef_ffee, 7},
    '{88'h11_03_00fe_0002, 6, 56'h11_03_04_ff01_ff00, 7},
    '{88'h11_04_0020_0002, 6, 56'h11_04_04_ffde_ffdf, 7},
    '{88'h11_06_0005_1234, 6, 56'h11_06_0005_1234, 6},
    '{88'h11_10_0008_0002_04_aabb_ccdd, 11, 56'h11_10_0008_0002, 6},
    '{88'h11_10_0000_007c_f8, 7, 56'h11_90_03, 3},
    '{88'h11_10_0000_0000_00, 7, 56'h11_90_03, 3},
    '{88'h11_07_0000_0001, 6, 56'h11_87_01, 3},
    '{88'h11_03_0000_0000, 6, 56'h11_83_03, 3},
    '{88'h11_03_0000_007e, 6, 56'h11_83_03, 3},
    '{88'h11_03_00ff_0002, 6, 56'h11_83_02, 3},
    '{88'h11_03_00ee_0001, 6, 56'h11_83_04, 3},
    '{88'h11_04_00ee_0001, 6, 56'h11_84_04, 3},
    '{88'h11_06_00ee_0001, 6, 56'h11_86_04, 3},
    '{88'h11_06_0100_0001, 6, 56'h11_86_02, 3},
    '{88'h12_03_0010_0001, 6, 56'h0, 0},
    '{88'h00_03_0010_0001, 6, 56'h0, 0}
  };
  mrs_slave #(.CLK_HZ(1_000_000), .HOLD_COUNT(256), .INPUT_COUNT(256)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .own_addr_i(own_addr_i), .baud_sel_i(baud_sel_i),
    .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i), .rx_err_i(rx_err_i),
    .tx_busy_i(tx_busy_i), .tx_data_o(tx_data_o), .tx_start_o(tx_start_o),
    .tx_drive_o(tx_drive_o), .reg_req_o(reg_req_o), .reg_we_o(reg_we_o),
    .reg_input_o(reg_input_o), .reg_addr_o(reg_addr_o), .reg_wdata_o(reg_wdata_o),
    .reg_rdata_i(reg_rdata_i), .reg_ack_i(reg_ack_i), .reg_err_i(reg_err_i));
  mrs_master_model model (
    .mclk_i(mclk_i), .tx_data_i(tx_data_o), .tx_start_i(tx_start_o),
    .tx_drive_i(tx_drive_o), .rx_data_o(rx_data_i), .rx_valid_o(rx_valid_i),
    .rx_err_o(rx_err_i), .tx_busy_o(tx_busy_i));
  always #10 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 100000) begin
      bad_count++;
      conclude();
    end
  end
  // Application side: slow ack, data from address, failure at 00eeh
  always @(negedge mclk_i) begin
    reg_ack_i <= 1'b0;
    if (reg_req_o !== 1'b1) rq_age <= 0;
    else if (rq_age == 2) begin
      reg_ack_i   <= 1'b1;
      reg_rdata_i <= ~reg_addr_o ^ {15'h0000, reg_input_o};
      reg_err_i   <= (reg_addr_o == 16'h00ee);
      rq_age      <= -4;
      if (reg_we_o && reg_addr_o != 16'h00ee) wr_last <= {reg_addr_o, reg_wdata_o};
    end else rq_age <= rq_age + 1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [7:0] b [$]);
    logic [15:0] v;
    v = 16'hffff;
    foreach (b[i]) begin
      v ^= {8'h00, b[i]};
      repeat (8) v = v[0] ? (v >> 1) ^ 16'ha001 : v >> 1;
    end
    return v;
  endfunction
  task automatic transact(input logic [7:0] rq [$], input logic [7:0] rp [$],
                          input bit bad_crc, input int gap_at, input int err_at);
    logic [15:0] c;
    int          w;
    c = crc16(rq) ^ {15'h0000, bad_crc};
    rq.push_back(c[7:0]);
    rq.push_back(c[15:8]);
    c = crc16(rp);
    if (rp.size() > 0) rp.push_back(c[7:0]);
    if (rp.size() > 0) rp.push_back(c[15:8]);
    model.send(rq, gap_at, err_at);
    w = 0;
    while (model.got.size() < rp.size() + (rp.size() == 0) && w < 2500) begin
      @(negedge mclk_i);
      w++;
    end
    check("reply length", rp.size(), model.got.size());
    foreach (rp[i]) if (i < model.got.size()) check("reply byte", rp[i], model.got[i]);
    if (rp.size() > 0) check("lead silence", 1, model.first_tx - model.last_rx >= END_CYC);
    w = 0;
    while (tx_drive_o !== 1'b0 && w < 200) begin
      @(negedge mclk_i);
      w++;
    end
    check("driver released", 0, tx_drive_o);
    repeat (END_CYC + 10) @(negedge mclk_i);
  endtask
  task automatic conclude();
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    rst_n_i = 1'b0;
    own_addr_i = 8'h11;
    baud_sel_i = 3'h4;
    {reg_ack_i, reg_err_i, reg_rdata_i, wr_last} = '0;
    {bad_count, n_compared, cycles, rq_age} = '0;
    repeat (2) @(negedge mclk_i);
    rst_n_i = 1'b1;
    repeat (END_CYC + 10) @(negedge mclk_i);
    foreach (rows[i]) begin
      q.delete();
      e.delete();
      for (int k = rows[i].rl - 1; k >= 0; k--) q.push_back(rows[i].rq[8*k +: 8]);
      for (int k = rows[i].pl - 1; k >= 0; k--) e.push_back(rows[i].rp[8*k +: 8]);
      transact(q, e, 1'b0, -1, -1);
    end
    e.delete();
    q = '{8'h11, 8'h06, 8'h00, 8'h05, 8'h00, 8'h07};
    transact(q, e, 1'b1, -1, -1);
    transact(q, e, 1'b0, 3, -1);
    transact(q, e, 1'b0, -1, 2);
    check("dropped frames wrote", 32'h0009ccdd, wr_last);
    q[0] = 8'h00;
    transact(q, e, 1'b0, -1, -1);
    check("broadcast write", 32'h00050007, wr_last);
    // Slower rate from here on, so the silence timer decode is exercised
    baud_sel_i = 3'h3;
    q = '{8'h11, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01};
    fork
      model.send(q, -1, -1);
      begin
        repeat (150) @(negedge mclk_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge mclk_i);
        check("outputs in reset", 0, {tx_drive_o, tx_start_o, reg_req_o});
        rst_n_i = 1'b1;
      end
    join
    repeat (2500) @(negedge mclk_i);
    check("reply after reset", 0, model.got.size());
    e = '{8'h11, 8'h03, 8'h02, 8'hff, 8'hef};
    transact(q, e, 1'b0, -1, -1);
    check("slower silence", 1, model.first_tx - model.last_rx >= END_CYC3);
    check("driver during receive", 0, model.drive_bad);
    conclude();
  end
endmodule
